// File: hdl/uart_mode_control.sv
// Operation
// - reset loads each channel mode register with 01h
// - bit and byte writes accepted; rewriting same value disturbs nothing
// - power bit 7 low stops channel clock and resets channel logic
// - power off clears error status, tx status, break bits 7:6, rx buffer
// - power off forces transmit line high and receive view high
// - bit 6 enables transmitter; low resets transmitter synchronously
// - bit 5 enables receiver; low resets receiver synchronously
// - bits 4:3 pick parity none, zero, odd or even
// - zero parity reception never checks or flags parity error
// - bit 2 selects 7 or 8 data bits both directions
// - bit 1 selects one or two transmit stop bits
// - receiver always uses exactly one stop bit
// - bit 0 routes error completion to error or normal interrupt
// - enabled receiver starts at once if line already low
// - enables synced to base clock; two base clocks between off and on
// - two channels with identical mode registers at ff2eh and ff2fh
// - 7-bit character lands in bits 6:0 with bit 7 zero
// - transmit buffer write starts transmission on a base clock edge
// - error status reads 00h after reset, power off or rx off
`timescale 1ns/100ps
module uart_mode_control
  import uart_mode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_pos,
  input wire logic i_bit_val,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_serial_base_clock,
  input wire logic [1:0] i_serial_in,
  output logic [1:0] o_serial_out,
  output logic [15:0] o_receive_buffer,
  output logic [1:0] o_rx_valid,
  input wire logic [1:0] i_rx_ready,
  output logic [1:0] o_rx_complete_irq,
  output logic [1:0] o_rx_error_irq,
  output logic [1:0] o_tx_done
);
  logic rst_q1;
  logic rst_q2;
  logic [7:0] channel_mode_register [2];
  logic [7:0] rx_error_status [2];
  logic [7:0] tx_status [2];
  logic [7:0] break_control [2];
  logic [7:0] transmit_buffer [2];
  logic [7:0] next_rdata;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  function automatic logic [15:0] addr_of(input logic [15:0] a0, input logic [15:0] a1,
                                          input int c);
    addr_of = (c == 0) ? a0 : a1;
  endfunction

  for (genvar c = 0; c < 2; c++) begin : g_chan
    localparam logic [15:0] MODE_A = addr_of(MODE0_ADDR, MODE1_ADDR, c);
    localparam logic [15:0] RXERR_A = addr_of(RXERR0_ADDR, RXERR1_ADDR, c);
    localparam logic [15:0] TXBUF_A = addr_of(TXBUF0_ADDR, TXBUF1_ADDR, c);
    localparam logic [15:0] BRK_A = addr_of(BRK0_ADDR, BRK1_ADDR, c);

    logic power;
    logic tx_en_sync;
    logic rx_en_sync;
    logic tick;
    logic len8;
    logic [1:0] par_sel;
    logic rx_view;
    tx_state_t tx_state;
    logic [3:0] tx_tick_cnt;
    logic [2:0] tx_bit_cnt;
    logic [7:0] tx_shift;
    logic tx_line;
    logic tx_second_stop;
    logic tx_done;
    rx_state_t rx_state;
    logic [3:0] rx_tick_cnt;
    logic [2:0] rx_bit_cnt;
    logic [7:0] rx_shift;
    logic rx_par_sample;
    logic rx_finish;
    logic rx_pe;
    logic rx_fe;
    logic rx_ove;
    logic [7:0] rx_word;
    logic fifo_ready;
    logic rx_irq_ok;
    logic rx_irq_err;
    logic err_rd;
    logic txbuf_wr;

    assign power = channel_mode_register[c][POWER_BIT];
    assign len8 = channel_mode_register[c][CL_BIT];
    assign par_sel = channel_mode_register[c][PAR_HI_BIT:PAR_LO_BIT];
    assign tick = i_serial_base_clock[c];
    assign rx_view = power ? i_serial_in[c] : 1'b1;
    assign err_rd = i_rd && (i_addr == RXERR_A);
    assign txbuf_wr = i_wr && (i_addr == TXBUF_A) && power && tx_en_sync;

    // write effects depend on the stored value only, so a refresh is harmless
    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        channel_mode_register[c] <= MODE_RESET;
      end else if (i_wr && i_addr == MODE_A) begin
        channel_mode_register[c] <= i_wdata;
      end else if (i_bit_wr && i_addr == MODE_A) begin
        channel_mode_register[c][i_bit_pos] <= i_bit_val;
      end
    end

    // enables follow the base clock, not the bus write
    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        tx_en_sync <= 1'b0;
        rx_en_sync <= 1'b0;
      end else if (!power) begin
        tx_en_sync <= 1'b0;
        rx_en_sync <= 1'b0;
      end else if (tick) begin
        tx_en_sync <= channel_mode_register[c][TXE_BIT];
        rx_en_sync <= channel_mode_register[c][RXE_BIT];
      end
    end

    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        break_control[c] <= BRK_RESET;
      end else if (!power) begin
        break_control[c] <= BRK_RESET;
      end else if (i_wr && i_addr == BRK_A) begin
        break_control[c] <= i_wdata & BRK_MASK;
      end
    end

    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        transmit_buffer[c] <= BUF_RESET;
      end else if (txbuf_wr) begin
        transmit_buffer[c] <= i_wdata;
      end
    end

    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        tx_state <= TX_IDLE;
        tx_tick_cnt <= '0;
        tx_bit_cnt <= '0;
        tx_shift <= '0;
        tx_line <= 1'b1;
        tx_second_stop <= 1'b0;
        tx_status[c] <= STATUS_RESET;
        tx_done <= 1'b0;
      end else if (!power || !tx_en_sync) begin
        tx_state <= TX_IDLE;
        tx_tick_cnt <= '0;
        tx_bit_cnt <= '0;
        tx_line <= 1'b1;
        tx_second_stop <= 1'b0;
        tx_status[c] <= STATUS_RESET;
        tx_done <= 1'b0;
      end else begin
        tx_done <= 1'b0;
        if (txbuf_wr) begin
          tx_status[c][TXBF_BIT] <= 1'b1;
        end
        if (tick) begin
          tx_tick_cnt <= tx_tick_cnt + 4'h1;
          unique case (tx_state)
            TX_IDLE: begin
              tx_tick_cnt <= '0;
              if (tx_status[c][TXBF_BIT]) begin
                tx_shift <= transmit_buffer[c];
                tx_status[c][TXBF_BIT] <= txbuf_wr;
                tx_status[c][TXSF_BIT] <= 1'b1;
                tx_line <= 1'b0;
                tx_state <= TX_START;
              end
            end
            TX_START: begin
              if (tx_tick_cnt == BIT_LAST) begin
                tx_line <= tx_shift[0];
                tx_bit_cnt <= '0;
                tx_state <= TX_DATA;
              end
            end
            TX_DATA: begin
              if (tx_tick_cnt == BIT_LAST) begin
                tx_bit_cnt <= tx_bit_cnt + 3'h1;
                if (tx_bit_cnt == (len8 ? LEN8_LAST : LEN7_LAST)) begin
                  if (par_sel != PAR_NONE) begin
                    tx_line <= parity_of(tx_shift, len8, par_sel);
                    tx_state <= TX_PARITY;
                  end else begin
                    tx_line <= 1'b1;
                    tx_state <= TX_STOP;
                  end
                end else begin
                  tx_line <= tx_shift[3'(tx_bit_cnt + 3'h1)];
                end
              end
            end
            TX_PARITY: begin
              if (tx_tick_cnt == BIT_LAST) begin
                tx_line <= 1'b1;
                tx_state <= TX_STOP;
              end
            end
            TX_STOP: begin
              if (tx_tick_cnt == BIT_LAST) begin
                if (channel_mode_register[c][SL_BIT] && !tx_second_stop) begin
                  tx_second_stop <= 1'b1;
                end else begin
                  tx_second_stop <= 1'b0;
                  tx_done <= 1'b1;
                  // back-to-back frame when the buffer already holds a byte
                  if (tx_status[c][TXBF_BIT]) begin
                    tx_shift <= transmit_buffer[c];
                    tx_status[c][TXBF_BIT] <= txbuf_wr;
                    tx_line <= 1'b0;
                    tx_state <= TX_START;
                  end else begin
                    tx_status[c][TXSF_BIT] <= 1'b0;
                    tx_state <= TX_IDLE;
                  end
                end
              end
            end
          endcase
        end
      end
    end

    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        rx_state <= RX_IDLE;
        rx_tick_cnt <= '0;
        rx_bit_cnt <= '0;
        rx_shift <= '0;
        rx_par_sample <= 1'b0;
      end else if (!power || !rx_en_sync) begin
        rx_state <= RX_IDLE;
        rx_tick_cnt <= '0;
        rx_bit_cnt <= '0;
      end else if (tick) begin
        rx_tick_cnt <= rx_tick_cnt + 4'h1;
        unique case (rx_state)
          RX_IDLE: begin
            rx_tick_cnt <= '0;
            if (!rx_view) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tick_cnt == BIT_HALF && rx_view) begin
              rx_state <= RX_IDLE;
            end else if (rx_tick_cnt == BIT_LAST) begin
              rx_bit_cnt <= '0;
              rx_state <= RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tick_cnt == BIT_HALF) begin
              rx_shift <= {rx_view, rx_shift[7:1]};
            end
            if (rx_tick_cnt == BIT_LAST) begin
              rx_bit_cnt <= rx_bit_cnt + 3'h1;
              if (rx_bit_cnt == (len8 ? LEN8_LAST : LEN7_LAST)) begin
                rx_state <= (par_sel != PAR_NONE) ? RX_PARITY : RX_STOP;
              end
            end
          end
          RX_PARITY: begin
            if (rx_tick_cnt == BIT_HALF) begin
              rx_par_sample <= rx_view;
            end
            if (rx_tick_cnt == BIT_LAST) begin
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_tick_cnt == BIT_HALF) begin
              rx_state <= RX_IDLE;
            end
          end
        endcase
      end
    end

    assign rx_finish = power && rx_en_sync && tick && (rx_state == RX_STOP) &&
                       (rx_tick_cnt == BIT_HALF);
    assign rx_word = len8 ? rx_shift : {1'b0, rx_shift[7:1]};
    assign rx_fe = !rx_view;
    // zero parity and no parity are never judged
    assign rx_pe = par_sel[1] && (parity_of(rx_word, len8, par_sel) != rx_par_sample);
    assign rx_ove = !fifo_ready;

    // a new error in the read cycle survives the read
    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        rx_error_status[c] <= STATUS_RESET;
      end else if (!power || !rx_en_sync) begin
        rx_error_status[c] <= STATUS_RESET;
      end else begin
        rx_error_status[c] <= (err_rd ? STATUS_RESET : rx_error_status[c]) |
          (rx_finish ? {5'h00, rx_pe, rx_fe, rx_ove} : STATUS_RESET);
      end
    end

    always_ff @(posedge i_clk or negedge rst_q2) begin
      if (!rst_q2) begin
        rx_irq_ok <= 1'b0;
        rx_irq_err <= 1'b0;
      end else begin
        rx_irq_ok <= rx_finish &&
          (!(rx_pe || rx_fe || rx_ove) || channel_mode_register[c][ROUTE_BIT]);
        rx_irq_err <= rx_finish && (rx_pe || rx_fe || rx_ove) &&
          !channel_mode_register[c][ROUTE_BIT];
      end
    end

    // an overrun frame is dropped rather than stalling the line
    uart_rx_pair_buffer #(
      .WIDTH(8),
      .DEPTH(2)
    ) u_rx_buf (
      .i_clk(i_clk),
      .i_rst_n(rst_q2),
      .i_clear(!power),
      .i_data(rx_word),
      .i_valid(rx_finish && !rx_ove),
      .o_ready(fifo_ready),
      .o_data(o_receive_buffer[c*8 +: 8]),
      .o_valid(o_rx_valid[c]),
      .i_ready(i_rx_ready[c])
    );

    assign o_serial_out[c] = tx_line;
    assign o_rx_complete_irq[c] = rx_irq_ok;
    assign o_rx_error_irq[c] = rx_irq_err;
    assign o_tx_done[c] = tx_done;
  end

  always_comb begin
    unique case (i_addr)
      MODE0_ADDR: next_rdata = channel_mode_register[0];
      MODE1_ADDR: next_rdata = channel_mode_register[1];
      RXERR0_ADDR: next_rdata = rx_error_status[0];
      RXERR1_ADDR: next_rdata = rx_error_status[1];
      TXSTAT0_ADDR: next_rdata = tx_status[0];
      TXSTAT1_ADDR: next_rdata = tx_status[1];
      TXBUF0_ADDR: next_rdata = transmit_buffer[0];
      TXBUF1_ADDR: next_rdata = transmit_buffer[1];
      BRK0_ADDR: next_rdata = break_control[0];
      BRK1_ADDR: next_rdata = break_control[1];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_q2) begin
    if (!rst_q2) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end
endmodule

// File: hdl/uart_mode_pkg.sv
package uart_mode_pkg;
  localparam logic [15:0] MODE0_ADDR = 16'hff2e;
  localparam logic [15:0] MODE1_ADDR = 16'hff2f;
  localparam logic [15:0] RXERR0_ADDR = 16'hff60;
  localparam logic [15:0] RXERR1_ADDR = 16'hff61;
  localparam logic [15:0] TXSTAT0_ADDR = 16'hff62;
  localparam logic [15:0] TXSTAT1_ADDR = 16'hff63;
  localparam logic [15:0] TXBUF0_ADDR = 16'hff64;
  localparam logic [15:0] TXBUF1_ADDR = 16'hff65;
  localparam logic [15:0] BRK0_ADDR = 16'hff66;
  localparam logic [15:0] BRK1_ADDR = 16'hff67;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'hff;
  localparam logic [7:0] BRK_RESET = 8'h00;
  localparam int POWER_BIT = 7;
  localparam int TXE_BIT = 6;
  localparam int RXE_BIT = 5;
  localparam int PAR_HI_BIT = 4;
  localparam int PAR_LO_BIT = 3;
  localparam int CL_BIT = 2;
  localparam int SL_BIT = 1;
  localparam int ROUTE_BIT = 0;
  localparam int PE_BIT = 2;
  localparam int FE_BIT = 1;
  localparam int OVE_BIT = 0;
  localparam int TXBF_BIT = 1;
  localparam int TXSF_BIT = 0;
  localparam logic [7:0] BRK_MASK = 8'hc0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] BIT_HALF = 4'h7;
  localparam logic [2:0] LEN7_LAST = 3'h6;
  localparam logic [2:0] LEN8_LAST = 3'h7;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_PARITY = 5'b01000, TX_STOP = 5'b10000
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
    RX_PARITY = 5'b01000, RX_STOP = 5'b10000
  } rx_state_t;

  function automatic logic parity_of(input logic [7:0] d, input logic len8,
                                     input logic [1:0] sel);
    logic ones;
    ones = ^(len8 ? d : {1'b0, d[6:0]});
    case (sel)
      PAR_ODD: parity_of = ~ones;
      PAR_EVEN: parity_of = ones;
      default: parity_of = 1'b0;
    endcase
  endfunction
endpackage

// File: hdl/uart_rx_pair_buffer.sv
`timescale 1ns/100ps
module uart_rx_pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != (PW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_ptr];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // cleared contents read as all ones, like an empty receive buffer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '1;
    end else if (i_clear) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '1;
    end else begin
      // a popped slot reads as empty again, so a drained buffer shows all ones
      if (pop) begin
        mem[rd_ptr] <= '1;
      end
      if (push) begin
        mem[wr_ptr] <= i_data;
      end
    end
  end
endmodule

// File: sim/uart_mode_control_props.sv
`timescale 1ns/100ps
module uart_mode_control_props
  import uart_mode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_pos,
  input wire logic i_bit_val,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_serial_out,
  input wire logic [15:0] o_receive_buffer,
  input wire logic [1:0] o_rx_valid,
  input wire logic [1:0] o_rx_complete_irq,
  input wire logic [1:0] o_rx_error_irq,
  input wire logic [1:0] o_tx_done
);
  logic [7:0] m0, m1, rsel;
  logic [1:0] pw, pw_d;
  logic mapped;
  // shadow of both mode registers; byte write wins over bit write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m0 <= 8'h01;
      m1 <= 8'h01;
    end else if (i_wr) begin
      if (i_addr == MODE0_ADDR) m0 <= i_wdata;
      if (i_addr == MODE1_ADDR) m1 <= i_wdata;
    end else if (i_bit_wr) begin
      if (i_addr == MODE0_ADDR) m0[i_bit_pos] <= i_bit_val;
      if (i_addr == MODE1_ADDR) m1[i_bit_pos] <= i_bit_val;
    end
  end
  // power-off clearing lands one edge after the bit falls
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) pw_d <= 2'h0;
    else pw_d <= pw;
  end
  assign pw = {m1[7], m0[7]};
  assign rsel = (i_addr == MODE1_ADDR) ? m1 : m0;
  assign mapped = (i_addr == MODE0_ADDR) || (i_addr == MODE1_ADDR) ||
                  (i_addr >= RXERR0_ADDR && i_addr <= BRK1_ADDR);

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_mode_rd;
    i_rd && (i_addr == MODE0_ADDR || i_addr == MODE1_ADDR) |=> o_rdata == $past(rsel);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read differs from shadow");
  property p_unmapped_rd;
    i_rd && !mapped |=> o_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_rdata_hold;
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_off_line;
    (~pw & ~pw_d & ~o_serial_out) == 2'h0;
  endproperty
  a_off_line: assert property (p_off_line) else $error("line low while unpowered");
  property p_off_empty;
    (~pw & ~pw_d & o_rx_valid) == 2'h0;
  endproperty
  a_off_empty: assert property (p_off_empty) else $error("data valid while unpowered");
  property p_empty_ff;
    (o_rx_valid[0] || o_receive_buffer[7:0] == 8'hff) &&
    (o_rx_valid[1] || o_receive_buffer[15:8] == 8'hff);
  endproperty
  a_empty_ff: assert property (p_empty_ff) else $error("empty buffer not ff");
  property p_irq_excl;
    (o_rx_complete_irq & o_rx_error_irq) == 2'h0;
  endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("both receive irqs at once");
  property p_irq_valid;
    |o_rx_complete_irq |-> (o_rx_valid & o_rx_complete_irq) == o_rx_complete_irq;
  endproperty
  a_irq_valid: assert property (p_irq_valid) else $error("irq without buffered byte");
  property p_done_line;
    (o_tx_done & ~$past(o_serial_out)) == 2'h0;
  endproperty
  a_done_line: assert property (p_done_line) else $error("frame end with line low");
  property p_done_gap;
    o_tx_done[0] |=> !o_tx_done[0] [*8];
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("frame end pulses too close");
  c_tx: cover property (o_tx_done[0]);
  c_rx: cover property (o_rx_complete_irq[1]);
  c_err: cover property (o_rx_error_irq[1]);
endmodule

bind uart_mode_control uart_mode_control_props props_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .i_bit_wr(i_bit_wr),
  .i_bit_pos(i_bit_pos), .i_bit_val(i_bit_val), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_serial_out(o_serial_out), .o_receive_buffer(o_receive_buffer), .o_rx_valid(o_rx_valid),
  .o_rx_complete_irq(o_rx_complete_irq), .o_rx_error_irq(o_rx_error_irq),
  .o_tx_done(o_tx_done));

// File: sim/serial_node.sv
`timescale 1ns/100ps
module serial_node #(
  parameter int BIT_CYC = 32
) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'b1;
  // frames go back to back with no idle gap between them
  task automatic send(input logic [11:0] v, input int n, input int nf);
    for (int f = 0; f < nf; f++) begin
      for (int i = 0; i < n; i++) begin
        o_line <= v[i];
        repeat (BIT_CYC) @(posedge i_clk);
      end
    end
    o_line <= 1'b1;
  endtask
  // samples mid-bit, well away from the line's transitions
  task automatic capture(input int n, output logic [11:0] v);
    v = '1;
    wait (i_line === 1'b0);
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      v[i] = i_line;
      if (i < n - 1) repeat (BIT_CYC) @(posedge i_clk);
    end
  endtask
endmodule

// File: sim/uart_mode_control_tb.sv
`timescale 1ns/100ps
module uart_mode_control_tb;
  import uart_mode_pkg::*;
  localparam int BIT_CYC = 32;
  localparam int LIMIT = 40000;
  logic i_clk, i_rst_n, i_wr, i_bit_wr, i_bit_val, i_rd;
  logic [15:0] i_addr, o_receive_buffer;
  logic [7:0] i_wdata, o_rdata, m, ex;
  logic [2:0] i_bit_pos;
  logic [1:0] tick, i_rx_ready, o_serial_out, o_rx_valid, o_rx_complete_irq, o_rx_error_irq;
  logic [1:0] o_tx_done;
  wire [1:0] sin;
  logic [11:0] v, got;
  int fails, checks_done, cyc, ncmp, nerr, ndone, n, nc, ne, nd, nf, k;
  logic [4:0] tcfg [4] = '{5'h05, 5'h0c, 5'h16, 5'h18};
  logic [7:0] tdat [4] = '{8'ha5, 8'h3c, 8'h81, 8'hb5};
  logic [4:0] rcfg [6] = '{5'h04, 5'h00, 5'h14, 5'h0c, 5'h15, 5'h1e};
  logic [7:0] rdat [6] = '{8'ha3, 8'hd5, 8'h6e, 8'h6e, 8'h6e, 8'h39};
  logic rflip [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  uart_mode_control uart_mode_control_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .i_bit_wr(i_bit_wr),
    .i_bit_pos(i_bit_pos), .i_bit_val(i_bit_val), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_serial_base_clock(tick), .i_serial_in(sin), .o_serial_out(o_serial_out),
    .o_receive_buffer(o_receive_buffer), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .o_rx_complete_irq(o_rx_complete_irq), .o_rx_error_irq(o_rx_error_irq),
    .o_tx_done(o_tx_done));
  serial_node #(.BIT_CYC(BIT_CYC)) p0 (.i_clk(i_clk), .i_line(o_serial_out[0]), .o_line(sin[0]));
  serial_node #(.BIT_CYC(BIT_CYC)) p1 (.i_clk(i_clk), .i_line(o_serial_out[1]), .o_line(sin[1]));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // base clock tick every second cycle: one bit is 32 cycles
  always @(posedge i_clk) tick <= #1 {2{~tick[0]}};
  // pulses are counted on the falling edge, clear of register updates
  always @(negedge i_clk) begin
    cyc++;
    if (o_rx_complete_irq[1] === 1'b1) ncmp++;
    if (o_rx_error_irq[1] === 1'b1) nerr++;
    if (o_tx_done[0] === 1'b1) ndone++;
    if (cyc == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(posedge i_clk);
    #1 i_wr = 1'b0;
    idle(1);
  endtask
  task automatic bwr(input logic [15:0] a, input logic [2:0] p, input logic b);
    i_addr = a;
    i_bit_pos = p;
    i_bit_val = b;
    i_bit_wr = 1'b1;
    @(posedge i_clk);
    #1 i_bit_wr = 1'b0;
    idle(1);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_clk);
    #1 i_rd = 1'b0;
    chk(16'(o_rdata), 16'(e));
    idle(1);
  endtask
  task automatic pop();
    i_rx_ready[1] = 1'b1;
    @(posedge i_clk);
    #1 i_rx_ready[1] = 1'b0;
    idle(1);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // frame bits from start to stop; two stops only counted for transmit
  function automatic int frame(input logic [7:0] d, input logic [7:0] md, input logic tx,
                               output logic [11:0] fv);
    int c;
    logic p;
    fv = '1;
    fv[0] = 1'b0;
    c = 1;
    p = ^(md[2] ? d : {1'b0, d[6:0]});
    for (int i = 0; i < (md[2] ? 8 : 7); i++) begin
      fv[c] = d[i];
      c++;
    end
    if (md[4:3] != 2'h0) begin
      fv[c] = (md[4:3] == 2'h2) ? ~p : ((md[4:3] == 2'h3) ? p : 1'b0);
      c++;
    end
    return c + 1 + int'(tx & md[1]);
  endfunction

  initial begin
    {i_rst_n, i_wr, i_bit_wr, i_bit_val, i_rd, i_addr, i_wdata, i_bit_pos} = '0;
    {tick, i_rx_ready} = '0;
    idle(20);
    i_rst_n = 1'b1;
    idle(3);
    rd_chk(MODE0_ADDR, 8'h01);
    rd_chk(MODE1_ADDR, 8'h01);
    rd_chk(RXERR1_ADDR, 8'h00);
    rd_chk(16'hff00, 8'h00);
    wr(RXERR1_ADDR, 8'hff);
    rd_chk(RXERR1_ADDR, 8'h00);
    bwr(MODE0_ADDR, 3'h7, 1'b1);
    rd_chk(MODE0_ADDR, 8'h81);
    bwr(MODE0_ADDR, 3'h0, 1'b0);
    rd_chk(MODE0_ADDR, 8'h80);
    for (k = 0; k < 4; k++) begin
      m = {3'b100, tcfg[k]};
      wr(MODE0_ADDR, m);
      wr(MODE0_ADDR, m | 8'h40);
      idle(8);
      n = frame(tdat[k], m, 1'b1, v);
      nd = ndone;
      fork
        p0.capture(n, got);
        begin
          wr(TXBUF0_ADDR, tdat[k]);
          wr(MODE0_ADDR, m | 8'h40);
        end
      join
      #1;
      chk(16'(got), 16'(v));
      chk(16'(ndone - nd), 16'h0000);
      for (int w = 0; w < 40 && ndone == nd; w++) @(posedge i_clk);
      #1;
      chk(16'(ndone - nd), 16'h0001);
      wr(MODE0_ADDR, m);
      idle(8);
    end
    wr(MODE0_ADDR, 8'h84);
    wr(MODE0_ADDR, 8'hc4);
    idle(8);
    wr(TXBUF0_ADDR, 8'h00);
    idle(100);
    wr(MODE0_ADDR, 8'h04);
    idle(2);
    chk(16'(o_serial_out[0]), 16'h0001);
    rd_chk(TXSTAT0_ADDR, 8'h00);
    for (k = 0; k < 6; k++) begin
      m = {3'b100, rcfg[k]};
      wr(MODE1_ADDR, m);
      wr(MODE1_ADDR, m | 8'h20);
      idle(8);
      n = frame(rdat[k], m, 1'b0, v);
      v[n - 2] = v[n - 2] ^ rflip[k];
      nf = (k == 5) ? 2 : 1;
      ne = int'(rflip[k] & m[4] & ~m[0]);
      ex = m[2] ? rdat[k] : {1'b0, rdat[k][6:0]};
      nc = ncmp;
      nd = nerr;
      p1.send(v, n, nf);
      idle(4);
      chk(16'(ncmp - nc), 16'(nf - ne));
      chk(16'(nerr - nd), 16'(ne));
      rd_chk(RXERR1_ADDR, (rflip[k] & m[4]) ? 8'h04 : 8'h00);
      repeat (nf) begin
        chk(16'(o_receive_buffer[15:8]), 16'(ex));
        pop();
      end
      chk(16'(o_rx_valid[1]), 16'h0000);
      wr(MODE1_ADDR, m);
      idle(8);
    end
    wr(MODE1_ADDR, 8'ha4);
    idle(8);
    n = frame(8'h5a, 8'h84, 1'b0, v);
    nc = ncmp;
    nd = nerr;
    p1.send(v, n, 3);
    idle(4);
    chk(16'(ncmp - nc), 16'h0002);
    chk(16'(nerr - nd), 16'h0001);
    chk(16'(o_receive_buffer[15:8]), 16'h005a);
    rd_chk(RXERR1_ADDR, 8'h01);
    wr(MODE1_ADDR, 8'h84);
    wr(MODE1_ADDR, 8'h04);
    idle(3);
    chk(16'(o_rx_valid[1]), 16'h0000);
    chk(16'(o_receive_buffer[15:8]), 16'h00ff);
    rd_chk(RXERR1_ADDR, 8'h00);
    chk(16'(o_serial_out[1]), 16'h0001);
    stop_test();
  end
endmodule
